/* verilog/usmim_pkg.sv */
`default_nettype none
package usmim_pkg;
  // ****************************************************
  // Register map
  // ****************************************************
  localparam logic [5:0] OFS_MODE = 6'h04;
  localparam logic [5:0] OFS_IER = 6'h08;
  localparam logic [5:0] OFS_IDR = 6'h0c;
  localparam logic [5:0] OFS_IMR = 6'h10;
  localparam logic [5:0] OFS_CSR = 6'h14;
  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  localparam logic [9:0] MASK_RST = 10'h000;
  // Writable bits of the mode register
  localparam logic [31:0] MODE_WMASK = 32'h0006_fff0;
  // ****************************************************
  // Mode register fields
  // ****************************************************
  localparam int CLKS_LSB = 4;
  localparam int CHARLEN_LSB = 6;
  localparam int SYNC_BIT = 8;
  localparam int PARITY_LSB = 9;
  localparam int STOP_LSB = 12;
  localparam int CHM_LSB = 14;
  localparam int NINE_SEL_BIT = 17;
  localparam int CLK_OUT_BIT = 18;
  localparam int NUM_IRQ = 10;
  // Fixed prescale for the divided clock source
  localparam int MASTER_DIV = 8;
  // ****************************************************
  // Encodings
  // ****************************************************
  localparam logic [1:0] CHM_NORMAL = 2'h0;
  localparam logic [1:0] CHM_ECHO = 2'h1;
  localparam logic [1:0] CHM_LOCAL = 2'h2;
  localparam logic [1:0] CHM_REMOTE = 2'h3;
  localparam logic [1:0] STOP_ONE = 2'h0;
  localparam logic [1:0] STOP_ONEHALF = 2'h1;
  localparam logic [1:0] STOP_TWO = 2'h2;
  // Parity selections
  localparam logic [2:0] PARITY_EVEN = 3'h0;
  localparam logic [2:0] PARITY_ODD = 3'h1;
  localparam logic [2:0] PARITY_SPACE = 3'h2;
  localparam logic [2:0] PARITY_MARK = 3'h3;
  localparam logic [3:0] BITS_FIVE = 4'h5;
  localparam logic [3:0] BITS_NINE = 4'h9;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    WR_IDLE = 3'b001,
    WR_RESP = 3'b010,
    WR_HOLD = 3'b100
  } usmim_wr_t;
endpackage
`default_nettype wire

/* verilog/usmim_top.sv */
// Overview of operation
// - Clock source: master, master/8, external pin
// - Length field picks five to eight bits
// - Sync bit selects async or synchronous
// - Parity field: even, odd, forced, none, multidrop
// - Async stop bits one, one-half, two
// - Normal mode: transmitter drives line
// - Echo mode copies receive data out
// - Local loopback feeds transmitter to receiver
// - Remote loopback ties receive pin out
// - Nine-bit select forces nine data bits
// - Clock pin driven only if enabled, internal
// - Enable write of one sets mask
// - Disable write of one clears mask
// - Ten interrupt sources at fixed bits
// - Interrupt high when flag and mask set
// - Mask view resets zero, shows enables
// - Nine-bit mode disables transfer channels
`timescale 1ns/1ns
`default_nettype none
module usmim_top #(
  parameter int ADDR_W = 6
) (
  // Clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Status flags from the transfer engines
  input wire logic [9:0] channel_status_flags_i,
  // Serial engine side
  input wire logic tx_engine_out_i,
  input wire logic baud_tick_i,
  output logic rx_engine_in_o,
  output logic baud_clk_en_o,
  output logic [3:0] data_bits_o,
  output logic sync_mode_o,
  output logic [2:0] parity_type_sel_o,
  output logic multidrop_o,
  output logic [1:0] stop_halves_o,
  output logic engines_bypass_o,
  output logic xfer_chan_off_o,
  // Line pins
  input wire logic rxd_i,
  output logic txd_o,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_o,
  // Interrupt
  output logic irq_o
);
  // ****************************************************
  // Register storage
  // ****************************************************
  logic [31:0] serial_mode_config_r;
  logic [9:0] irq_mask_view_r;
  logic [2:0] prescale_r;
  logic sck_d_r;
  usmim_pkg::usmim_wr_t wr_state_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic aw_have_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic w_have_r;

  // Mode fields
  logic [1:0] clock_source_sel;
  logic [1:0] char_length_sel;
  logic [2:0] parity_type_sel;
  logic [1:0] stop_bit_count_sel;
  logic [1:0] channel_test_mode;
  logic nine_bit_select;
  logic serial_clock_out_en_field;
  assign clock_source_sel = serial_mode_config_r[usmim_pkg::CLKS_LSB+:2];
  assign char_length_sel = serial_mode_config_r[usmim_pkg::CHARLEN_LSB+:2];
  assign parity_type_sel = serial_mode_config_r[usmim_pkg::PARITY_LSB+:3];
  assign stop_bit_count_sel = serial_mode_config_r[usmim_pkg::STOP_LSB+:2];
  assign channel_test_mode = serial_mode_config_r[usmim_pkg::CHM_LSB+:2];
  assign nine_bit_select = serial_mode_config_r[usmim_pkg::NINE_SEL_BIT];
  assign serial_clock_out_en_field =
    serial_mode_config_r[usmim_pkg::CLK_OUT_BIT];

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i+:8] = new_v[8*i+:8];
      end
    end
    return res;
  endfunction

  // Address decode, used by read and write paths
  function automatic logic is_addr(input logic [ADDR_W-1:0] a,
                                   input logic [5:0] ofs);
    return a[5:2] == ofs[5:2];
  endfunction

  // ****************************************************
  // AXI write channel
  // ****************************************************
  logic wr_fire;
  assign wr_fire = (wr_state_r == usmim_pkg::WR_IDLE) && aw_have_r &&
                   w_have_r;

  // Address and data taken in either order, then one response
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      wr_state_r <= usmim_pkg::WR_IDLE;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= usmim_pkg::RESP_OKAY;
    end else if (clk_en_i) begin
      case (wr_state_r)
        usmim_pkg::WR_IDLE: begin
          s_axi_awready_o <= !aw_have_r &&
                             !(s_axi_awvalid_i && s_axi_awready_o);
          s_axi_wready_o <= !w_have_r &&
                            !(s_axi_wvalid_i && s_axi_wready_o);
          if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_have_r <= 1'b1;
            awaddr_r <= s_axi_awaddr_i;
          end
          if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_have_r <= 1'b1;
            wdata_r <= s_axi_wdata_i;
            wstrb_r <= s_axi_wstrb_i;
          end
          if (wr_fire) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            // Read-only or unmapped targets answer with an error
            if (is_addr(awaddr_r, usmim_pkg::OFS_MODE) ||
                is_addr(awaddr_r, usmim_pkg::OFS_IER) ||
                is_addr(awaddr_r, usmim_pkg::OFS_IDR)) begin
              s_axi_bresp_o <= usmim_pkg::RESP_OKAY;
            end else begin
              s_axi_bresp_o <= usmim_pkg::RESP_SLVERR;
            end
            wr_state_r <= usmim_pkg::WR_RESP;
          end
        end
        usmim_pkg::WR_RESP: begin
          if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
            wr_state_r <= usmim_pkg::WR_HOLD;
          end
        end
        usmim_pkg::WR_HOLD: begin
          // One idle cycle so ready reopens cleanly
          wr_state_r <= usmim_pkg::WR_IDLE;
        end
        default: begin
          wr_state_r <= usmim_pkg::WR_IDLE;
        end
      endcase
    end
  end

  // ****************************************************
  // Mode register and interrupt mask
  // ****************************************************
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      serial_mode_config_r <= usmim_pkg::MODE_RST;
    end else if (clk_en_i && wr_fire &&
                 is_addr(awaddr_r, usmim_pkg::OFS_MODE)) begin
      serial_mode_config_r <= merge(serial_mode_config_r, wdata_r,
                                    wstrb_r) & usmim_pkg::MODE_WMASK;
    end
  end

  // Mask bits per source; enable and disable only touch ones
  logic [31:0] ier_word;
  logic [31:0] idr_word;
  assign ier_word = merge(32'h0000_0000, wdata_r, wstrb_r);
  assign idr_word = ier_word;
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      irq_mask_view_r <= usmim_pkg::MASK_RST;
    end else if (clk_en_i && wr_fire) begin
      if (is_addr(awaddr_r, usmim_pkg::OFS_IER)) begin
        irq_mask_view_r <= irq_mask_view_r |
                           ier_word[usmim_pkg::NUM_IRQ-1:0];
      end else if (is_addr(awaddr_r, usmim_pkg::OFS_IDR)) begin
        irq_mask_view_r <= irq_mask_view_r &
                           ~idr_word[usmim_pkg::NUM_IRQ-1:0];
      end
    end
  end

  // ****************************************************
  // AXI read channel
  // ****************************************************
  // Data registered one cycle after the address is taken
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= usmim_pkg::RESP_OKAY;
    end else if (clk_en_i) begin
      if (s_axi_rvalid_o) begin
        if (s_axi_rready_i) begin
          s_axi_rvalid_o <= 1'b0;
        end
        s_axi_arready_o <= 1'b0;
      end else if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o <= usmim_pkg::RESP_OKAY;
        if (is_addr(s_axi_araddr_i, usmim_pkg::OFS_MODE)) begin
          s_axi_rdata_o <= serial_mode_config_r;
        end else if (is_addr(s_axi_araddr_i, usmim_pkg::OFS_IMR)) begin
          s_axi_rdata_o <= {22'h00_0000, irq_mask_view_r};
        end else if (is_addr(s_axi_araddr_i, usmim_pkg::OFS_CSR)) begin
          s_axi_rdata_o <= {22'h00_0000, channel_status_flags_i};
        end else begin
          // Write-only and unmapped read as zero with error
          s_axi_rdata_o <= 32'h0000_0000;
          s_axi_rresp_o <= usmim_pkg::RESP_SLVERR;
        end
      end else begin
        s_axi_arready_o <= 1'b1;
      end
    end
  end

  // ****************************************************
  // Interrupt output
  // ****************************************************
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      irq_o <= 1'b0;
    end else if (clk_en_i) begin
      irq_o <= |(channel_status_flags_i & irq_mask_view_r);
    end
  end

  // ****************************************************
  // Baud generator clock source
  // ****************************************************
  // Prescaler free-runs while clk_en_i is high; mode writes never reset the /8 phase
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      prescale_r <= 3'h0;
      sck_d_r <= 1'b0;
    end else if (clk_en_i) begin
      prescale_r <= prescale_r + 3'h1;
      sck_d_r <= sck_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      baud_clk_en_o <= 1'b0;
    end else if (clk_en_i) begin
      if (clock_source_sel[1]) begin
        baud_clk_en_o <= sck_i && !sck_d_r; // external rising edge
      end else if (clock_source_sel[0]) begin
        baud_clk_en_o <=
          prescale_r == 3'(usmim_pkg::MASTER_DIV - 1);
      end else begin
        baud_clk_en_o <= 1'b1;
      end
    end
  end

  // ****************************************************
  // Frame format decode
  // ****************************************************
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      data_bits_o <= usmim_pkg::BITS_FIVE;
      sync_mode_o <= 1'b0;
      parity_type_sel_o <= usmim_pkg::PARITY_EVEN;
      multidrop_o <= 1'b0;
      stop_halves_o <= 2'h2;
      xfer_chan_off_o <= 1'b0;
    end else if (clk_en_i) begin
      if (nine_bit_select) begin
        data_bits_o <= usmim_pkg::BITS_NINE;
      end else begin
        data_bits_o <= usmim_pkg::BITS_FIVE + {2'b00, char_length_sel};
      end
      sync_mode_o <= serial_mode_config_r[usmim_pkg::SYNC_BIT];
      parity_type_sel_o <= parity_type_sel;
      multidrop_o <= parity_type_sel[2] && parity_type_sel[1];
      // Stop length counted in half bits
      case (stop_bit_count_sel)
        usmim_pkg::STOP_ONEHALF: begin
          // sync reserved code treated as one
          stop_halves_o <= serial_mode_config_r[usmim_pkg::SYNC_BIT] ?
                           2'h2 : 2'h3;
        end
        usmim_pkg::STOP_TWO: begin
          stop_halves_o <= 2'h0; // zero encodes four halves
        end
        default: begin
          stop_halves_o <= 2'h2;
        end
      endcase
      xfer_chan_off_o <= nine_bit_select;
    end
  end

  // ****************************************************
  // Channel test mode routing and clock pin
  // ****************************************************
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      txd_o <= 1'b1;
      rx_engine_in_o <= 1'b1;
      engines_bypass_o <= 1'b0;
      sck_o <= 1'b0;
      sck_oe_o <= 1'b0;
    end else if (clk_en_i) begin
      case (channel_test_mode)
        usmim_pkg::CHM_ECHO: begin
          txd_o <= rxd_i;
          rx_engine_in_o <= rxd_i;
          engines_bypass_o <= 1'b0;
        end
        usmim_pkg::CHM_LOCAL: begin
          txd_o <= 1'b1;
          rx_engine_in_o <= tx_engine_out_i;
          engines_bypass_o <= 1'b0;
        end
        usmim_pkg::CHM_REMOTE: begin
          txd_o <= rxd_i;
          rx_engine_in_o <= 1'b1;
          engines_bypass_o <= 1'b1;
        end
        default: begin
          txd_o <= tx_engine_out_i;
          rx_engine_in_o <= rxd_i;
          engines_bypass_o <= 1'b0;
        end
      endcase
      sck_oe_o <= serial_clock_out_en_field && !clock_source_sel[1];
      sck_o <= baud_tick_i;
    end
  end
endmodule
`default_nettype wire

/* verif/usmim_props.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Port checker for mode and mask block
// ****************************************
module usmim_props (
  // Clock and control
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // Register bus
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  // Interrupt and line side
  input wire logic [9:0] channel_status_flags_i,
  input wire logic irq_o,
  input wire logic rxd_i,
  input wire logic txd_o,
  input wire logic rx_engine_in_o,
  input wire logic engines_bypass_o,
  // Decoded mode
  input wire logic xfer_chan_off_o,
  input wire logic [3:0] data_bits_o,
  input wire logic sync_mode_o,
  input wire logic [1:0] stop_halves_o,
  input wire logic [2:0] parity_type_sel_o,
  input wire logic multidrop_o
);
  // Frozen cycles are skipped, since outputs only hold then
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i || !clk_en_i);
  // Write steps: both halves taken, then answer two edges on
  sequence wr_both_s;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence wr_ans_s;
    ##2 s_axi_bvalid_o;
  endsequence
  // Bus timing and single beats
  wr_answer_a: assert property (wr_both_s |-> wr_ans_s)
    else $error("write answer late");
  wr_single_a: assert property (s_axi_bvalid_o && s_axi_bready_i |=>
    !s_axi_bvalid_o) else $error("write answer repeated");
  rd_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=>
    s_axi_rvalid_o) else $error("read answer late");
  rd_single_a: assert property (s_axi_rvalid_o && s_axi_rready_i |=>
    !s_axi_rvalid_o) else $error("read answer repeated");
  // Interrupt cause, mode decoding and line routing
  // Outputs held over a frozen cycle are not checked against it
  irq_cause_a: assert property ($past(clk_en_i) && irq_o |->
    $past(|channel_status_flags_i)) else $error("interrupt without flag");
  remote_loop_a: assert property ($past(clk_en_i) &&
    engines_bypass_o |-> txd_o == $past(rxd_i) && rx_engine_in_o)
    else $error("remote path");
  nine_bits_a: assert property (xfer_chan_off_o |->
    data_bits_o == usmim_pkg::BITS_NINE) else $error("nine bit length");
  char_len_a: assert property (xfer_chan_off_o ||
    data_bits_o inside {[4'h5:4'h8]}) else $error("length range");
  stop_code_a: assert property (stop_halves_o != 2'h1 &&
    !(sync_mode_o && stop_halves_o == 2'h3)) else $error("stop length");
  multi_drop_a: assert property (multidrop_o ==
    (parity_type_sel_o[2:1] == 2'h3)) else $error("multidrop decode");
endmodule
bind usmim_top usmim_props i_props (.*);
`default_nettype wire

/* verif/usmim_peer.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Remote serial peer
// ****************************************
module usmim_peer (
  // Clock and frame request
  input wire logic ref_clk_i,
  input wire logic peer_go,
  input wire logic [7:0] peer_byte,
  input wire logic [1:0] peer_per,
  // Line pins
  output logic rxd_i,
  output logic sck_i,
  output logic peer_busy
);
  logic [9:0] sh_r = 10'h3ff;
  logic [3:0] cnt_r = 4'h0;
  logic [1:0] div_r = 2'h0;
  logic sck_r = 1'h0;
  // Start bit, eight data bits low first, stop; slow when per high
  always @(posedge ref_clk_i) begin
    if (peer_go && cnt_r == 4'h0) begin
      sh_r <= {1'h1, peer_byte, 1'h0};
      cnt_r <= 4'ha;
      div_r <= peer_per;
    end else if (cnt_r != 4'h0) begin
      if (div_r == 2'h0) begin
        sh_r <= {1'h1, sh_r[9:1]};
        cnt_r <= cnt_r - 4'h1;
        div_r <= peer_per;
      end else begin
        div_r <= div_r - 2'h1;
      end
    end
    sck_r <= (cnt_r != 4'h0) ? ~sck_r : 1'h0;
  end
  // Idle line rests high; clock stands still outside frames
  assign rxd_i = sh_r[0];
  assign sck_i = sck_r;
  assign peer_busy = cnt_r != 4'h0;
endmodule
`default_nettype wire

/* verif/usmim_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module usmim_bench;
  // ****************************************
  // Connections
  // ****************************************
  logic ref_clk_i = 1'h0, sys_rst_i = 1'h1, clk_en_i = 1'h1;
  logic [5:0] s_axi_awaddr_i = 6'h00, s_axi_araddr_i = 6'h00;
  logic [31:0] s_axi_wdata_i = 32'h0000_0000, s_axi_rdata_o;
  logic [3:0] s_axi_wstrb_i = 4'hf, data_bits_o;
  logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0;
  logic s_axi_bready_i = 1'h0, s_axi_arvalid_i = 1'h0;
  logic s_axi_rready_i = 1'h0, s_axi_awready_o, s_axi_wready_o;
  logic s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, stop_halves_o, peer_per = 2'h0;
  logic [9:0] channel_status_flags_i = 10'h000;
  logic tx_engine_out_i = 1'h1, baud_tick_i = 1'h0, rxd_i, sck_i;
  logic rx_engine_in_o, baud_clk_en_o, sync_mode_o, multidrop_o;
  logic [2:0] parity_type_sel_o;
  logic engines_bypass_o, xfer_chan_off_o, txd_o, sck_o, sck_oe_o, irq_o;
  logic peer_go = 1'h0, peer_busy;
  logic [7:0] peer_byte = 8'h00;
  int bad_count = 0, checks_done = 0;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  usmim_top i_dut (.*);
  usmim_peer i_peer (.*);
  // Clock
  always #20 ref_clk_i = ~ref_clk_i;
  // Random engine-side stimulus
  always @(posedge ref_clk_i) begin
    tx_engine_out_i <= 1'($urandom);
    baud_tick_i <= 1'($urandom);
  end
  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic chk(input string nm, input logic [33:0] e, g);
    checks_done++;
    if (e !== g) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 200) begin
      bad_count++;
      $display("[ERR] bus wait expected answer seen none");
      end_of_test();
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    bq.push_back(r);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'h1;
    s_axi_wvalid_i <= 1'h1;
    s_axi_bready_i <= 1'h1;
    do begin
      @(posedge ref_clk_i);
      n++;
      if (s_axi_awready_o && s_axi_awvalid_i) s_axi_awvalid_i <= 1'h0;
      if (s_axi_wready_o && s_axi_wvalid_i) s_axi_wvalid_i <= 1'h0;
    end while (!(s_axi_bvalid_o && s_axi_bready_i) && n < 200);
    s_axi_bready_i <= 1'h0;
    tmo(n);
  endtask
  task automatic rd(input logic [5:0] a, input logic [33:0] e);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    rq.push_back(e);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'h1;
    s_axi_rready_i <= 1'h1;
    do begin
      @(posedge ref_clk_i);
      n++;
      if (s_axi_arready_o && s_axi_arvalid_i) s_axi_arvalid_i <= 1'h0;
    end while (!(s_axi_rvalid_o && s_axi_rready_i) && n < 200);
    s_axi_rready_i <= 1'h0;
    tmo(n);
  endtask
  // Bus answers taken off the note queues in order
  always @(posedge ref_clk_i) begin
    if (s_axi_bvalid_o && s_axi_bready_i)
      chk("bresp", bq.pop_front(), s_axi_bresp_o);
    if (s_axi_rvalid_o && s_axi_rready_i)
      chk("rdata", rq.pop_front(), {s_axi_rresp_o, s_axi_rdata_o});
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    logic [31:0] v, m;
    logic pr, pt, pb, ps, pq;
    int k, c;
    v = $urandom(32'hd3000d35);
    repeat (12) @(posedge ref_clk_i);
    sys_rst_i <= 1'h0;
    rd(usmim_pkg::OFS_MODE, 34'h0_0000_0000);
    rd(usmim_pkg::OFS_IMR, 34'h0_0000_0000);
    rd(6'h00, {usmim_pkg::RESP_SLVERR, 32'h0000_0000});
    rd(usmim_pkg::OFS_IER, {usmim_pkg::RESP_SLVERR, 32'h0000_0000});
    // Every length, parity, stop, source code; reserved bits random
    for (k = 0; k < 8; k++) begin
      v = $urandom;
      {v[18:17], v[15:4]} = {k[0], k > 5, 2'h0, k[1:0], k[2:0], k[2],
                             k[1:0], k[2:1]};
      wr(usmim_pkg::OFS_MODE, v, usmim_pkg::RESP_OKAY);
      rd(usmim_pkg::OFS_MODE, {2'h0, v & usmim_pkg::MODE_WMASK});
      @(negedge ref_clk_i);
      chk("bits", k > 5 ? 4'h9 : 4'h5 + k[1:0], data_bits_o);
      chk("sync", k[2], sync_mode_o);
      chk("parity", k[2:0], parity_type_sel_o);
      chk("multidrop", k[2:1] == 2'h3, multidrop_o);
      chk("stop", k[1:0] == 2'h2 ? 2'h0 : k == 1 ? 2'h3 : 2'h2,
          stop_halves_o);
      chk("xfer_off", k > 5, xfer_chan_off_o);
      chk("sck_oe", k[0] & ~k[2], sck_oe_o);
      c = 0;
      repeat (16) begin
        @(negedge ref_clk_i);
        c += (baud_clk_en_o === 1'h1);
      end
      chk("baud", k[2] ? 0 : k[1] ? 2 : 16, c);
    end
    // Channel modes with the peer sending, prompt and slow in turn;
    // baud source on the external pin so its edges are counted
    for (k = 0; k < 4; k++) begin
      wr(usmim_pkg::OFS_MODE, 32'h0000_2120 | (k << 14),
         usmim_pkg::RESP_OKAY);
      repeat (2) @(posedge ref_clk_i);
      // Let a slow frame finish so each mode sees a fresh one
      for (c = 0; c < 40 && peer_busy; c++) @(posedge ref_clk_i);
      peer_go <= 1'h1;
      peer_byte <= 8'($urandom);
      peer_per <= {k[0], 1'h0};
      for (c = 0; c < 14; c++) begin
        @(negedge ref_clk_i);
        if (c == 1) peer_go <= 1'h0;
        if (c > 0) begin
          chk("txd", k == 2 ? 1'h1 : k[0] ? pr : pt, txd_o);
          chk("rx_in", k == 3 ? 1'h1 : k == 2 ? pt : pr,
              rx_engine_in_o);
          chk("sck", pb, sck_o);
        end
        if (c > 1) chk("baud_ext", ps & ~pq, baud_clk_en_o);
        pr = rxd_i;
        pt = tx_engine_out_i;
        pb = baud_tick_i;
        pq = ps;
        ps = sck_i;
      end
    end
    // Mask set and clear, read-only refusal
    v = $urandom;
    m = $urandom;
    wr(usmim_pkg::OFS_IER, v, usmim_pkg::RESP_OKAY);
    rd(usmim_pkg::OFS_IMR, {24'h00_0000, v[9:0]});
    wr(usmim_pkg::OFS_IDR, m, usmim_pkg::RESP_OKAY);
    rd(usmim_pkg::OFS_IMR, {24'h00_0000, v[9:0] & ~m[9:0]});
    wr(usmim_pkg::OFS_IMR, 32'hffff_ffff, usmim_pkg::RESP_SLVERR);
    rd(usmim_pkg::OFS_IMR, {24'h00_0000, v[9:0] & ~m[9:0]});
    // One source at a time: masked flags stay quiet
    for (k = 0; k < 10; k++) begin
      wr(usmim_pkg::OFS_IDR, 32'h0000_03ff, usmim_pkg::RESP_OKAY);
      wr(usmim_pkg::OFS_IER, 32'h0000_0001 << k, usmim_pkg::RESP_OKAY);
      rd(usmim_pkg::OFS_IMR, 34'h0_0000_0001 << k);
      channel_status_flags_i <= ~(10'h001 << k);
      repeat (3) @(negedge ref_clk_i);
      chk("irq_off", 1'h0, irq_o);
      rd(usmim_pkg::OFS_CSR, {24'h00_0000, ~(10'h001 << k)});
      channel_status_flags_i <= (10'h001 << k) | 10'($urandom);
      repeat (3) @(negedge ref_clk_i);
      chk("irq_on", 1'h1, irq_o);
    end
    // Enable low freezes the interrupt output, then it follows again
    @(posedge ref_clk_i);
    clk_en_i <= 1'h0;
    channel_status_flags_i <= 10'h000;
    repeat (3) @(negedge ref_clk_i);
    chk("irq_hold", 1'h1, irq_o);
    @(posedge ref_clk_i);
    clk_en_i <= 1'h1;
    repeat (3) @(negedge ref_clk_i);
    chk("irq_drop", 1'h0, irq_o);
    end_of_test();
  end
endmodule
`default_nettype wire
